// [logic/apip_in_pack.v]
/*
  Packs one network's node input nibbles and master flags into its 32-byte input image.
  Assumes node n sits at bits 4n-4 upward of each node bus.
*/
`include "apip_map.vh"

module apip_in_pack (
  input wire [123:0] node_a,
  input wire [123:0] node_b,
  input wire [3:0] flags,
  output wire [255:0] image
);

  genvar j;
  //////////////////////////////////////////////////////////////////////////////
  // One pass per byte pair: A byte j and B byte j+16
  generate
    for (j = 0; j < 16; j = j + 1) begin : g_byte
      if (j == 0) begin : g_first
        assign image[7:0] = {flags, node_a[3:0]};
        assign image[135:128] = {4'h0, node_b[3:0]};
      end else begin : g_pair
        // High nibble node 2j, low nibble node 2j+1
        assign image[8*j +: 8] = {node_a[4*(2*j-1) +: 4], node_a[8*j +: 4]};
        assign image[128+8*j +: 8] = {node_b[4*(2*j-1) +: 4], node_b[8*j +: 4]};
      end
    end
  endgenerate

endmodule // apip_in_pack

// [logic/apip_map.vh]
/*
  Address map, field positions, reset values and instance codes of the process image packer.
  Assumes a 12-bit AXI4-Lite byte address and 32-bit data.
*/
// How it works
// - Input image is read by the controller; output image is written by it.
// - Selected input and output instance codes decide whether the images carry data.
// - Only standard/A nodes 1..31 and B nodes 1..31 are carried.
// - Single network: network 1 data fills image bytes 0 to 31.
// - Dual network: network 2 uses the same layout in bytes 32 to 63.
// - Input byte 0 of a network: flags 3..0 high, node 1/1A low.
// - Bytes 1..15: node 2n high nibble, node 2n+1 low nibble.
// - Byte 16: reserved high, 1B low; bytes 17..31 hold B pairs.
// - Output byte 0 high nibble unused, low is node 1/1A; rest as input.
// - Word k is byte 2k in bits 7..0 and byte 2k+1 above.
// - Output word 0 bits 7..4 unused; word 8 carries 2B, 3B, reserved, 1B.
`ifndef APIP_MAP_VH
`define APIP_MAP_VH

// Register and window offsets
`define APIP_CTRL_OFS 12'h000
`define APIP_STATUS_OFS 12'h004
`define APIP_IN_WIN 4'h1
`define APIP_OUT_WIN 4'h2

// Control fields
`define APIP_CTRL_DUAL 0
`define APIP_CTRL_IN_LSB 8
`define APIP_CTRL_OUT_LSB 16

// Status fields
`define APIP_ST_IN_OK 0
`define APIP_ST_OUT_OK 1
`define APIP_ST_DUAL 2
`define APIP_ST_CNT_LSB 8

// Instance codes
`define APIP_INST_OUT 8'h64
`define APIP_INST_IN 8'h65
`define APIP_INST_IN_DIAG 8'h67

// Reset value and image word counts
`define APIP_DUAL_RST 1'h1
`define APIP_WORDS 16
`define APIP_NET_WORDS 8

// AXI responses
`define APIP_RESP_OKAY 2'h0
`define APIP_RESP_SLVERR 2'h2

`endif

// [logic/apip_out_unpack.v]
/*
  Unpacks one network's 32-byte output image into node output nibbles.
  Assumes the image follows the input layout; unused and reserved nibbles are dropped.
*/
`include "apip_map.vh"

module apip_out_unpack (
  input wire [255:0] image,
  output wire [123:0] node_a,
  output wire [123:0] node_b
);

  genvar j;
  //////////////////////////////////////////////////////////////////////////////
  // Byte 0 and byte 16 high nibbles never reach a node
  generate
    for (j = 0; j < 16; j = j + 1) begin : g_byte
      if (j == 0) begin : g_first
        assign node_a[3:0] = image[3:0];
        assign node_b[3:0] = image[131:128];
      end else begin : g_pair
        assign node_a[4*(2*j-1) +: 4] = image[8*j+4 +: 4];
        assign node_a[8*j +: 4] = image[8*j +: 4];
        assign node_b[4*(2*j-1) +: 4] = image[128+8*j+4 +: 4];
        assign node_b[8*j +: 4] = image[128+8*j +: 4];
      end
    end
  endgenerate

endmodule // apip_out_unpack

// [logic/apip_top.v]
/*
  Process image packer top: AXI4-Lite slave exposing control, status, the
  digital input image and the digital output image of one or two networks.
  Map, as byte addresses:
    0x000 control: bit 0 dual network, bits 15..8 input instance code,
          bits 23..16 output instance code
    0x004 status, read only: bit 0 input code valid, bit 1 output code
          valid, bit 2 dual network, bits 15..8 count of stored writes
    0x100..0x13C input image words 0..15, packed live from the node pins
    0x200..0x23C output image words 0..15, held here
  Image byte b sits in word b/4, lane b%4; a 16-bit controller word k is
  half k%2 of bus word k/2. Words 0..7 carry network 1, 8..15 network 2.
  Reserved and unused output nibbles are not stored and read back as zero.
  Misaligned, read-only and unmapped accesses answer SLVERR.
  Both networks are always built; the dual bit only hides network 2.
  Assumes node data and master flags are synchronous to sys_clk and that
  the AXI master follows AXI4-Lite valid/ready rules.
*/
`include "apip_map.vh"

module apip_top (
  input wire sys_clk,
  input wire resetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [247:0] node_in_a,
  input wire [247:0] node_in_b,
  input wire [1:0] master_flag_bit0,
  input wire [1:0] master_flag_bit1,
  input wire [1:0] master_flag_bit2,
  input wire [1:0] master_flag_bit3,
  output reg [247:0] node_out_a,
  output reg [247:0] node_out_b,
  output reg out_image_update
);

  //////////////////////////////////////////////////////////////////////////////
  // Control and status state
  reg dual_net;
  reg [7:0] in_instance;
  reg [7:0] out_instance;
  reg [7:0] out_write_count;
  wire in_ok;
  wire out_ok;

  // Output image words, byte b of the image at word b/4, lane b%4
  reg [31:0] out_mem [0:15];

  // Write channel holding registers
  reg aw_got;
  reg [11:0] aw_addr;
  reg w_got;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire aw_take;
  wire w_take;
  wire wr_fire;

  // Read side
  wire ar_take;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  // Write decode
  reg [1:0] next_bresp;
  reg ctrl_we;
  reg out_we;
  reg [31:0] wr_word;
  reg [31:0] wr_mask;

  // Window hits and missing network 2 words
  wire wr_out_win;
  wire wr_net2_gone;
  wire rd_in_win;
  wire rd_out_win;
  wire rd_net2_gone;

  // Image buses
  wire [511:0] in_image;
  wire [511:0] out_image;
  wire [247:0] unpack_a;
  wire [247:0] unpack_b;
  wire [3:0] flags_net [0:1];

  // Loop index for clearing the output image in reset
  integer k;

  //////////////////////////////////////////////////////////////////////////////
  // Instance selection gates both images
  // Any other code zeroes input reads, or refuses output writes and zeroes the node outputs
  assign in_ok = (in_instance == `APIP_INST_IN) ||
                 (in_instance == `APIP_INST_IN_DIAG);
  assign out_ok = (out_instance == `APIP_INST_OUT);

  // Flags gathered per network, F3 on top
  // Network 2 flags are packed even when absent; its words then read zero
  assign flags_net[0] = {master_flag_bit3[0], master_flag_bit2[0],
                         master_flag_bit1[0], master_flag_bit0[0]};
  assign flags_net[1] = {master_flag_bit3[1], master_flag_bit2[1],
                         master_flag_bit1[1], master_flag_bit0[1]};

  //////////////////////////////////////////////////////////////////////////////
  // Per network packing and unpacking
  // Identical logic per network, network 2 in the upper halves
  genvar n;
  generate
    for (n = 0; n < 2; n = n + 1) begin : g_net
      apip_in_pack u_pack (
        .node_a(node_in_a[124*n +: 124]),
        .node_b(node_in_b[124*n +: 124]),
        .flags(flags_net[n]),
        .image(in_image[256*n +: 256])
      );
      apip_out_unpack u_unpack (
        .image(out_image[256*n +: 256]),
        .node_a(unpack_a[124*n +: 124]),
        .node_b(unpack_b[124*n +: 124])
      );
    end
    // Flatten the output words; bytes are little-endian inside each word
    // Word n holds image bytes 4n to 4n+3
    for (n = 0; n < `APIP_WORDS; n = n + 1) begin : g_word
      assign out_image[32*n +: 32] = out_mem[n];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Window decode: each window spans 64 bytes, anything above is unmapped
  assign wr_out_win = (aw_addr[11:8] == `APIP_OUT_WIN) && (aw_addr[7:6] == 2'h0);
  assign rd_in_win = (s_axi_araddr[11:8] == `APIP_IN_WIN) && (s_axi_araddr[7:6] == 2'h0);
  assign rd_out_win = (s_axi_araddr[11:8] == `APIP_OUT_WIN) && (s_axi_araddr[7:6] == 2'h0);
  // Words 8..15 carry network 2, absent in the single-network variant
  assign wr_net2_gone = aw_addr[5] && !dual_net;
  assign rd_net2_gone = s_axi_araddr[5] && !dual_net;

  //////////////////////////////////////////////////////////////////////////////
  // Address and data are accepted independently, in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  // Holding registers for the two write halves
  // A half taken early waits here; its ready stays low until the pair's write answer is taken
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_got <= 1'b0;
      aw_addr <= 12'h000;
      w_got <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got <= 1'b0;
      end
      if (w_take) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write decode: byte strobes become a bit mask
  // A refused write changes nothing; SLVERR tells the master why. Writes to
  // missing network 2 words are dropped quietly, since a controller may
  // send a full dual image to a single-network packer.
  always @* begin
    next_bresp = `APIP_RESP_OKAY;
    ctrl_we = 1'b0;
    out_we = 1'b0;
    wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wr_word = w_data;
    // Unused and reserved nibbles are never stored, so readback shows zero
    if (aw_addr[3:2] == 2'h0) begin
      wr_mask[7:4] = 4'h0;
    end
    if (aw_addr[1:0] != 2'h0) begin
      next_bresp = `APIP_RESP_SLVERR;
    end else if ((aw_addr == `APIP_CTRL_OFS)) begin
      ctrl_we = 1'b1;
    end else if (aw_addr == `APIP_STATUS_OFS) begin
      // Status is read only
      next_bresp = `APIP_RESP_SLVERR;
    end else if (wr_out_win) begin
      // Only the controller writes the output image
      if (!out_ok) begin
        next_bresp = `APIP_RESP_SLVERR;
      end else if (wr_net2_gone) begin
        out_we = 1'b0; // network 2 absent, data dropped
      end else begin
        out_we = 1'b1;
      end
    end else begin
      // Input image is read-only, everything else unmapped
      next_bresp = `APIP_RESP_SLVERR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register and output image updates, write response
  // The write count wraps at 256; software works with differences.
  // No new write fires while bvalid stands, so set and clear never meet.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dual_net <= `APIP_DUAL_RST;
      in_instance <= `APIP_INST_IN;
      out_instance <= `APIP_INST_OUT;
      out_write_count <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `APIP_RESP_OKAY;
      out_image_update <= 1'b0;
      for (k = 0; k < `APIP_WORDS; k = k + 1) begin
        out_mem[k] <= 32'h00000000;
      end
    end else begin
      out_image_update <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= next_bresp;
        if (ctrl_we) begin
          if (w_strb[0]) begin
            dual_net <= w_data[`APIP_CTRL_DUAL];
          end
          if (w_strb[1]) begin
            in_instance <= w_data[`APIP_CTRL_IN_LSB +: 8];
          end
          if (w_strb[2]) begin
            out_instance <= w_data[`APIP_CTRL_OUT_LSB +: 8];
          end
        end
        if (out_we) begin
          out_mem[aw_addr[5:2]] <= (out_mem[aw_addr[5:2]] & ~wr_mask) |
                                   (wr_word & wr_mask);
          out_write_count <= out_write_count + 8'h01;
          out_image_update <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Node outputs follow the stored image one cycle later
  // The extra stage keeps the pins a clean copy, free of decode glitches
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      node_out_a <= 248'h0;
      node_out_b <= 248'h0;
    end else if (!out_ok) begin
      // Without the output instance no node is driven
      node_out_a <= 248'h0;
      node_out_b <= 248'h0;
    end else begin
      node_out_a[123:0] <= unpack_a[123:0];
      node_out_b[123:0] <= unpack_b[123:0];
      // Network 2 stays quiet in the single-network variant
      node_out_a[247:124] <= dual_net ? unpack_a[247:124] : 124'h0;
      node_out_b[247:124] <= dual_net ? unpack_b[247:124] : 124'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel: one read in flight, answer one cycle after acceptance
  // arready drops while an answer waits, so no read is ever lost
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Read decode; the input image is packed live, so a read shows current inputs
  // Nothing is snapshotted: a word read while a node changes shows the new
  // value, which a cyclic exchange tolerates.
  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `APIP_RESP_OKAY;
    if (s_axi_araddr[1:0] != 2'h0) begin
      next_rresp = `APIP_RESP_SLVERR;
    end else if (s_axi_araddr == `APIP_CTRL_OFS) begin
      next_rdata[`APIP_CTRL_DUAL] = dual_net;
      next_rdata[`APIP_CTRL_IN_LSB +: 8] = in_instance;
      next_rdata[`APIP_CTRL_OUT_LSB +: 8] = out_instance;
    end else if (s_axi_araddr == `APIP_STATUS_OFS) begin
      next_rdata[`APIP_ST_IN_OK] = in_ok;
      next_rdata[`APIP_ST_OUT_OK] = out_ok;
      next_rdata[`APIP_ST_DUAL] = dual_net;
      next_rdata[`APIP_ST_CNT_LSB +: 8] = out_write_count;
    end else if (rd_in_win) begin
      // Network 2 words read zero when only one network exists
      if (in_ok && !rd_net2_gone) begin
        next_rdata = in_image[32*s_axi_araddr[5:2] +: 32];
      end
    end else if (rd_out_win) begin
      // Stored words read back as written, reserved nibbles as zero
      if (!rd_net2_gone) begin
        next_rdata = out_mem[s_axi_araddr[5:2]];
      end
    end else begin
      next_rresp = `APIP_RESP_SLVERR;
    end
  end

  // Read data register
  // Captured at the address handshake and held until rready
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `APIP_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // apip_top

// [test/apip_net_model.sv]
/* Node network model: node inputs and master flags of two networks.
   Assumes the bench changes pat just after a rising clock edge. */
module apip_net_model (
  input wire logic [7:0] pat,
  output logic [247:0] node_in_a,
  output logic [247:0] node_in_b,
  output logic [1:0] master_flag_bit0,
  output logic [1:0] master_flag_bit1,
  output logic [1:0] master_flag_bit2,
  output logic [1:0] master_flag_bit3
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // Only nodes 1..31 per network; neighbours differ to catch swaps
  always_comb begin
    for (int i = 0; i < 62; i++) begin
      node_in_a[4*i+:4] = 4'(i * 5) + pat[3:0];
      node_in_b[4*i+:4] = 4'(i * 3) ^ pat[7:4];
    end
  end
  // Network 1 flags in pat[3:0], network 2 in pat[7:4]
  assign master_flag_bit0 = {pat[4], pat[0]};
  assign master_flag_bit1 = {pat[5], pat[1]};
  assign master_flag_bit2 = {pat[6], pat[2]};
  assign master_flag_bit3 = {pat[7], pat[3]};
endmodule // apip_net_model

// [test/apip_top_assertions.sv]
/* Checker of the packer's bus handshakes and node outputs.
   Assumes it is bound into apip_top and sees only its ports. */
module apip_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [247:0] node_out_a,
  input wire logic out_image_update
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so one clocking and one reset mask
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Write answer rises the edge after the pair is held, read answer next edge
  a_write_lat: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Answers stand until taken
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  // No new request while an answer is pending
  a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // Update strobe: one cycle, only beside a good write answer
  a_upd_pulse: assert property (out_image_update |=> !out_image_update)
    else $error("update strobe too long");
  a_upd_resp: assert property (
    out_image_update |-> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("update without good write");
  // Node outputs move only after a write
  a_out_cause: assert property ($changed(node_out_a) |-> $past(s_axi_bvalid))
    else $error("node outputs changed unprompted");
endmodule // apip_chk

bind apip_top apip_chk u_chk (.sys_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .node_out_a, .out_image_update);

// [test/apip_top_test.sv]
/* Bench for apip_top: AXI4-Lite tasks and image checks.
   Assumes the map header, design files and node model are compiled. */
`include "apip_map.vh"
module apip_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire out_image_update;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [1:0] master_flag_bit0, master_flag_bit1, master_flag_bit2, master_flag_bit3;
  wire [31:0] s_axi_rdata;
  wire [247:0] node_in_a, node_in_b, node_out_a, node_out_b;
  logic [7:0] pat;
  logic [7:0] img [0:63];
  logic [7:0] codes [3] = '{8'h67, 8'h00, 8'h65};
  logic [11:0] bad [4] = '{12'h004, 12'h100, 12'h202, 12'h200};
  logic [1:0] r;
  int fails, tests_run, w;
  apip_top dut (.*);
  apip_net_model net (.*);
  ////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang;
    fails++;
    $display("MISMATCH handshake expected 1 seen 0");
    final_report;
  endtask
  task automatic tdone(string s);
    $display("test %s done, checks %0d mismatches %0d", s, tests_run, fails);
  endtask
  task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_nodes(string nm, logic [247:0] e, logic [247:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Bus master: both write halves at once, ready raised only on an answer
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ad, dd;
    int k;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; !(ad && dd); k++) begin
      @(negedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) ad = 1;
      if (s_axi_wvalid && s_axi_wready) dd = 1;
      @(posedge sys_clk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
      if (k > 50) hang();
    end
    for (k = 0; !s_axi_bvalid; k++) begin
      @(negedge sys_clk);
      if (k > 50) hang();
    end
    @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    @(negedge sys_clk);
    rs = s_axi_bresp;
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; !s_axi_arready; k++) begin
      @(negedge sys_clk);
      if (k > 50) hang();
    end
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    for (k = 0; !s_axi_rvalid; k++) begin
      @(negedge sys_clk);
      if (k > 50) hang();
    end
    @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    @(negedge sys_clk);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] wd(int i);
    return {img[4*i+3], img[4*i+2], img[4*i+1], img[4*i]};
  endfunction
  // Node nibbles of the first lim nodes as placed in img
  function automatic logic [247:0] nodes(bit b, int lim);
    int i, n, k;
    nodes = '0;
    for (i = 0; i < lim; i++) begin
      n = i % 31 + 1;
      k = i / 31 * 32 + n / 2 + (b ? 16 : 0);
      nodes[4*i+:4] = n % 2 ? img[k][3:0] : img[k][7:4];
    end
  endfunction
  // Input image for pattern p; bytes from lim upward read zero
  task automatic chk_in(input logic [7:0] p, input int lim);
    int i, n, k;
    logic [1:0] rs;
    @(posedge sys_clk);
    pat <= p;
    foreach (img[j]) img[j] = 8'h00;
    for (i = 0; i < 62; i++) begin
      n = i % 31 + 1;
      k = i / 31 * 32 + n / 2;
      if (n % 2) img[k][3:0] = 4'(i * 5) + p[3:0];
      else img[k][7:4] = 4'(i * 5) + p[3:0];
      if (n % 2) img[k+16][3:0] = 4'(i * 3) ^ p[7:4];
      else img[k+16][7:4] = 4'(i * 3) ^ p[7:4];
    end
    img[0][7:4] = p[3:0];
    img[32][7:4] = p[7:4];
    for (i = lim; i < 64; i++) img[i] = 8'h00;
    for (i = 0; i < 16; i++) begin
      rd({`APIP_IN_WIN, 8'(4 * i)}, d, rs);
      cmp_word("in_word", wd(i), d);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, resetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pat} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`APIP_CTRL_OFS, d, r);
    cmp_word("ctrl", 32'h00646501, d);
    rd(`APIP_STATUS_OFS, d, r);
    cmp_word("status", 32'h00000007, d);
    tdone("reset");
    chk_in(8'h00, 64);
    chk_in(8'hA7, 64);
    tdone("input dual");
    foreach (codes[j]) begin
      wr(`APIP_CTRL_OFS, {16'h0064, codes[j], 8'h01}, r);
      chk_in(8'h5C, codes[j] == 8'h00 ? 0 : 64);
    end
    wr(`APIP_CTRL_OFS, 32'h00646500, r);
    chk_in(8'h3E, 32);
    tdone("input instance and single");
    wr(`APIP_CTRL_OFS, 32'h00646501, r);
    foreach (img[j]) img[j] = 8'(j * 8'h1D + 8'h3C);
    for (w = 0; w < 16; w++) begin
      wr({`APIP_OUT_WIN, 8'(4 * w)}, wd(w), r);
      cmp_word("out_resp", 32'h00000000, {30'h0, r});
    end
    cmp_nodes("out_a", nodes(0, 62), node_out_a);
    cmp_nodes("out_b", nodes(1, 62), node_out_b);
    for (w = 0; w < 64; w += 16) img[w][7:4] = 4'h0;
    for (w = 0; w < 16; w++) begin
      rd({`APIP_OUT_WIN, 8'(4 * w)}, d, r);
      cmp_word("out_word", wd(w), d);
    end
    rd(`APIP_STATUS_OFS, d, r);
    cmp_word("status", 32'h00001007, d);
    wr(`APIP_CTRL_OFS, 32'h00646500, r);
    cmp_nodes("out_a", nodes(0, 31), node_out_a);
    cmp_nodes("out_b", nodes(1, 31), node_out_b);
    rd({`APIP_OUT_WIN, 8'h20}, d, r);
    cmp_word("net2_word", 32'h00000000, d);
    tdone("output");
    wr(`APIP_CTRL_OFS, 32'h00006501, r);
    cmp_nodes("out_a", 248'h0, node_out_a);
    cmp_nodes("out_b", 248'h0, node_out_b);
    foreach (bad[j]) begin
      wr(bad[j], 32'hFFFFFFFF, r);
      cmp_word("bresp", 32'h00000002, {30'h0, r});
    end
    rd(12'h300, d, r);
    cmp_word("rresp", 32'h00000002, {30'h0, r});
    cmp_word("rdata", 32'h00000000, d);
    tdone("refused");
    final_report;
  end
endmodule // apip_top_test
